// [rtl/wtu_regs.vh]
/*
 holds constants for the waveform timer capture, output and event block.
 assumes a single clock at 125 MHz; counter state arrives from the timer core.
*/
// Overview of operation
// - capture sets on-time entry flag A or B
// - software strobe captures; command ready marks valid
// - each of the two input events captures and steers counter
// - fault control zero on power-on, fuse-loaded after reset
// - enable bits gate outputs; levels give fault defaults
// - outputs C and D mirror A or B
// - override drives programmed per-phase levels
// - one-ramp: A and B each take their dead-A (level 0) entry outside their own phases
// - compare match strobes last one counter cycle
// - programmable event strobe lasts one cycle
// - event shares blanking trigger; blanking forces undelayed
// - trigger select 0x2 delays event by count
// - delay clock is sync clock over prescale
// - cycle-end source asserts at cycle completion
// - on-time entry flags set on phase entry
// - request asserted while enabled and flagged
// - shared vector requests ORed into one
// - runs in idle, stops in standby and power-down
// - fault control writes need key within four instructions
`ifndef WTU_REGS_VH
`define WTU_REGS_VH
`define WTU_CNT_W 12
`define WTU_FLAG_CYCLE_END 0
`define WTU_FLAG_ON_A 2
`define WTU_FLAG_ON_B 3
`define WTU_VEC_CYCLE_END 8'h00
`define WTU_VEC_ON_TIME 8'h02
`define WTU_FAULT_RESET 8'h00
`define WTU_KEY_WINDOW 3'h4
`define WTU_DLY_ON_TIME_ENTRY_VECTOR_DELAYED 2'h2
`define WTU_DLY_MAX 9'h100
`define WTU_PH_DEAD_A 2'h0
`define WTU_PH_ON_A 2'h1
`define WTU_PH_DEAD_B 2'h2
`define WTU_PH_ON_B 2'h3
`define WTU_SLEEP_IDLE 2'h1
`define WTU_SLEEP_STANDBY 2'h2
`define WTU_SLEEP_PDOWN 2'h3
`endif

// [rtl/wtu_event_delay.v]
/*
 programmable output event with prescaled delay counter.
 assumes trigger pulses come from the same clock domain.
*/
`include "wtu_regs.vh"
module wtu_event_delay (
	// clock, reset and run enable
	input wire clk,
	input wire reset_n,
	input wire run,
	// configuration
	input wire blanking_used,
	input wire [1:0] delay_trigger_select,
	input wire [1:0] delay_clock_divider,
	input wire [7:0] event_delay_count,
	// trigger and strobe
	input wire trigger,
	output reg event_strobe
);
	localparam ST_IDLE = 2'b01;
	localparam ST_WAIT = 2'b10;
	reg [1:0] state_q;
	reg [4:0] pre_q;
	reg [8:0] cnt_q;
	wire [4:0] pre_max;
	wire tick;
	wire delayed;
	// prescale factor 1, 2, 4 or 8
	assign pre_max = (5'h01 << delay_clock_divider) - 5'h01;
	assign tick = (pre_q == pre_max);
	assign delayed = (delay_trigger_select == `WTU_DLY_ON_TIME_ENTRY_VECTOR_DELAYED) && !blanking_used;
	always @(posedge clk) begin
		if (!reset_n) begin
			state_q <= ST_IDLE;
			pre_q <= 5'h00;
			cnt_q <= 9'h000;
			event_strobe <= 1'b0;
		end else begin
			event_strobe <= 1'b0;
			if (run) begin
				case (state_q)
					ST_IDLE: begin
						pre_q <= 5'h00;
						cnt_q <= 9'h000;
						if (trigger) begin
							if (!delayed || event_delay_count == 8'h00)
								event_strobe <= 1'b1;
							else
								state_q <= ST_WAIT;
						end
					end
					ST_WAIT: begin
						pre_q <= tick ? 5'h00 : pre_q + 5'h01;
						if (tick) begin
							cnt_q <= cnt_q + 9'h001;
							if (cnt_q + 9'h001 >= {1'b0, event_delay_count}) begin
								event_strobe <= 1'b1;
								state_q <= ST_IDLE;
							end
						end
					end
					default: state_q <= ST_IDLE;
				endcase
			end
		end
	end
endmodule // wtu_event_delay

// [rtl/wtu_output_events.v]
/*
 capture, output control, events, interrupts, sleep and write protection
 of the waveform timer unit.
 assumes counter value, phase and match pulses come from the timer core on clk;
 event inputs and fuse byte come from outside and are synchronised here.
*/
`include "wtu_regs.vh"
module wtu_output_events (
	// clock and reset
	input wire clk,
	input wire reset_n,
	input wire por_n,
	// timer core state
	input wire [11:0] counter_value,
	input wire [1:0] counter_phase,
	input wire phase_active,
	input wire one_ramp_mode,
	input wire cycle_end_pulse,
	input wire match_b_clear,
	input wire match_a_set,
	input wire match_b_set,
	input wire [1:0] sleep_mode,
	// event inputs
	input wire event_in_a,
	input wire event_in_b,
	input wire [1:0] event_input_control,
	input wire [1:0] input_mode_active,
	// software capture and capture readout
	input wire software_capture_a,
	input wire software_capture_b,
	output reg command_ready,
	output reg [11:0] captured_count_a,
	output reg [11:0] captured_count_b,
	output reg [1:0] counter_flow_event,
	// output configuration
	input wire out_c_source_select,
	input wire out_d_source_select,
	input wire output_override,
	input wire [3:0] override_levels_a,
	input wire [3:0] override_levels_b,
	input wire fault_active,
	// fault control protected write
	input wire [7:0] fuse_output_defaults,
	input wire key_write,
	input wire [7:0] key_value,
	input wire cpu_instr_done,
	input wire fault_ctrl_we,
	input wire [7:0] fault_ctrl_wdata,
	output reg [7:0] output_fault_control,
	// waveform outputs
	output reg waveform_out_a,
	output reg waveform_out_b,
	output reg waveform_out_c,
	output reg waveform_out_d,
	// events
	output reg compare_b_clear_point,
	output reg compare_a_set_point,
	output reg compare_b_set_point,
	input wire blanking_used,
	input wire [1:0] delay_trigger_select,
	input wire [1:0] delay_clock_divider,
	input wire [7:0] event_delay_count,
	input wire [1:0] event_trigger_source,
	output reg programmable_event,
	// interrupts
	input wire [3:0] interrupt_enable_register,
	input wire flag_write,
	input wire [3:0] flag_wdata,
	output reg [3:0] interrupt_flag_register,
	output reg cycle_end_source,
	output reg on_time_entry_vector
);
	localparam [7:0] IO_REGISTER_KEY = 8'hA5; // arbitrary
	reg [1:0] ev_s1_q;
	reg [1:0] ev_s2_q;
	reg [1:0] ev_s3_q;
	reg [7:0] fuse_s1_q;
	reg [7:0] fuse_s2_q;
	reg fuse_load_q;
	reg [2:0] key_cnt_q;
	reg [1:0] prev_phase_q;
	reg prev_act_q;
	reg [1:0] cap_pend_q;
	reg [3:0] flags_d;
	reg evt_src;
	wire run;
	wire [1:0] ev_rise;
	wire [1:0] cap_fire;
	wire ent_a;
	wire ent_b;
	wire lvl_a;
	wire lvl_b;
	wire a_out;
	wire b_out;
	wire evt_strobe;
	// override level picked by phase and one-ramp split
	function ovr_level;
		input [3:0] lv;
		input [1:0] ph;
		input own_a;
		input one_ramp;
		begin
			if (one_ramp && (own_a ? ph[1] : !ph[1]))
				ovr_level = lv[0];
			else
				ovr_level = lv[ph];
		end
	endfunction
	assign run = (sleep_mode != `WTU_SLEEP_STANDBY) && (sleep_mode != `WTU_SLEEP_PDOWN);
	assign ev_rise = ev_s2_q & ~ev_s3_q;
	assign cap_fire = (ev_rise & event_input_control) | {software_capture_b, software_capture_a};
	assign ent_a = phase_active && counter_phase == `WTU_PH_ON_A &&
		!(prev_act_q && prev_phase_q == `WTU_PH_ON_A);
	assign ent_b = phase_active && counter_phase == `WTU_PH_ON_B &&
		!(prev_act_q && prev_phase_q == `WTU_PH_ON_B);
	assign lvl_a = ovr_level(override_levels_a, counter_phase, 1'b1, one_ramp_mode);
	assign lvl_b = ovr_level(override_levels_b, counter_phase, 1'b0, one_ramp_mode);
	// A active in its on phase, B in its own
	assign a_out = fault_active ? output_fault_control[0] :
		output_override ? lvl_a : (phase_active && counter_phase == `WTU_PH_ON_A);
	assign b_out = fault_active ? output_fault_control[1] :
		output_override ? lvl_b : (phase_active && counter_phase == `WTU_PH_ON_B);
	always @* begin
		case (event_trigger_source)
			2'h0: evt_src = ev_rise[0];
			2'h1: evt_src = match_a_set;
			2'h2: evt_src = match_b_set;
			default: evt_src = match_b_clear;
		endcase
	end
	// flag update: set wins over clear
	always @* begin
		flags_d = interrupt_flag_register;
		if (flag_write)
			flags_d = flags_d & ~flag_wdata;
		if (run && cycle_end_pulse)
			flags_d[`WTU_FLAG_CYCLE_END] = 1'b1;
		if (run && (ent_a || cap_fire[0]))
			flags_d[`WTU_FLAG_ON_A] = 1'b1;
		if (run && (ent_b || cap_fire[1]))
			flags_d[`WTU_FLAG_ON_B] = 1'b1;
	end
	// synchronisers
	always @(posedge clk) begin
		if (!reset_n) begin
			ev_s1_q <= 2'h0;
			ev_s2_q <= 2'h0;
			ev_s3_q <= 2'h0;
		end else begin
			ev_s1_q <= {event_in_b, event_in_a};
			ev_s2_q <= ev_s1_q;
			ev_s3_q <= ev_s2_q;
		end
	end
	// fuse path runs through reset so the load after release sees the fuse
	always @(posedge clk) begin
		fuse_s1_q <= fuse_output_defaults;
		fuse_s2_q <= fuse_s1_q;
	end
	// fault control: clear at power-on, fuse load after reset, keyed writes
	always @(posedge clk) begin
		if (!por_n) begin
			output_fault_control <= `WTU_FAULT_RESET;
			fuse_load_q <= 1'b1;
			key_cnt_q <= 3'h0;
		end else if (!reset_n) begin
			fuse_load_q <= 1'b1;
			key_cnt_q <= 3'h0;
		end else begin
			if (fuse_load_q) begin
				output_fault_control <= fuse_s2_q;
				fuse_load_q <= 1'b0;
			end else if (fault_ctrl_we && key_cnt_q != 3'h0) begin
				output_fault_control <= fault_ctrl_wdata;
			end
			if (key_write && key_value == IO_REGISTER_KEY)
				key_cnt_q <= `WTU_KEY_WINDOW;
			else if (fault_ctrl_we)
				key_cnt_q <= 3'h0;
			else if (cpu_instr_done && key_cnt_q != 3'h0)
				key_cnt_q <= key_cnt_q - 3'h1;
		end
	end
	// capture, outputs, events, interrupts
	always @(posedge clk) begin
		if (!reset_n) begin
			captured_count_a <= 12'h000;
			captured_count_b <= 12'h000;
			cap_pend_q <= 2'h0;
			command_ready <= 1'b1;
			counter_flow_event <= 2'h0;
			prev_phase_q <= 2'h0;
			prev_act_q <= 1'b0;
			interrupt_flag_register <= 4'h0;
			waveform_out_a <= 1'b0;
			waveform_out_b <= 1'b0;
			waveform_out_c <= 1'b0;
			waveform_out_d <= 1'b0;
			compare_b_clear_point <= 1'b0;
			compare_a_set_point <= 1'b0;
			compare_b_set_point <= 1'b0;
			cycle_end_source <= 1'b0;
			on_time_entry_vector <= 1'b0;
		end else begin
			counter_flow_event <= 2'h0;
			compare_b_clear_point <= 1'b0;
			compare_a_set_point <= 1'b0;
			compare_b_set_point <= 1'b0;
			if (run) begin
				cap_pend_q <= cap_fire;
				command_ready <= (cap_fire == 2'h0);
				if (cap_pend_q[0])
					captured_count_a <= counter_value;
				if (cap_pend_q[1])
					captured_count_b <= counter_value;
				counter_flow_event <= ev_rise & input_mode_active;
				prev_phase_q <= counter_phase;
				prev_act_q <= phase_active;
				compare_b_clear_point <= match_b_clear;
				compare_a_set_point <= match_a_set;
				compare_b_set_point <= match_b_set;
				waveform_out_a <= output_fault_control[4] ? a_out : output_fault_control[0];
				waveform_out_b <= output_fault_control[5] ? b_out : output_fault_control[1];
				waveform_out_c <= output_fault_control[6] ? (out_c_source_select ? b_out : a_out) :
					output_fault_control[2];
				waveform_out_d <= output_fault_control[7] ? (out_d_source_select ? b_out : a_out) :
					output_fault_control[3];
			end
			interrupt_flag_register <= flags_d;
			cycle_end_source <= flags_d[`WTU_FLAG_CYCLE_END] & interrupt_enable_register[`WTU_FLAG_CYCLE_END];
			on_time_entry_vector <= (flags_d[`WTU_FLAG_ON_A] & interrupt_enable_register[`WTU_FLAG_ON_A]) |
				(flags_d[`WTU_FLAG_ON_B] & interrupt_enable_register[`WTU_FLAG_ON_B]);
		end
	end
	always @(posedge clk) begin
		if (!reset_n)
			programmable_event <= 1'b0;
		else
			programmable_event <= evt_strobe;
	end
	wtu_event_delay u_delay (
		.clk(clk),
		.reset_n(reset_n),
		.run(run),
		.blanking_used(blanking_used),
		.delay_trigger_select(delay_trigger_select),
		.delay_clock_divider(delay_clock_divider),
		.event_delay_count(event_delay_count),
		.trigger(evt_src),
		.event_strobe(evt_strobe)
	);
endmodule // wtu_output_events

// [verification/wtu_oe_sva.sv]
/* port checker for wtu_output_events.
 assumes binding by port name. */
module wtu_oe_sva (
	// clock and reset
	input wire clk, reset_n,
	// stimulus, flag register and captured count
	input wire match_a_set, match_b_clear, match_b_set, software_capture_a, cycle_end_pulse, flag_write,
	input wire [1:0] sleep_mode,
	input wire [3:0] interrupt_enable_register, flag_wdata, interrupt_flag_register,
	input wire [11:0] counter_value, captured_count_a,
	// results
	input wire compare_a_set_point, compare_b_clear_point, compare_b_set_point, command_ready,
	input wire cycle_end_source, on_time_entry_vector
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire run = !sleep_mode[1];
	wire [3:0] f = interrupt_flag_register;
	wire [3:0] e = interrupt_enable_register;
	sequence s_cap; software_capture_a && run; endsequence
	sequence s_clr; flag_write && flag_wdata[0] && !cycle_end_pulse; endsequence
	property p_as; match_a_set && run |=> compare_a_set_point; endproperty
	a_as: assert property (p_as) else $error("a set strobe missing");
	property p_bs; match_b_set && run |=> compare_b_set_point; endproperty
	a_bs: assert property (p_bs) else $error("b set strobe missing");
	property p_bc; !match_b_clear |=> !compare_b_clear_point; endproperty
	a_bc: assert property (p_bc) else $error("b clear strobe too long");
	property p_vec; $stable(e) |-> on_time_entry_vector == |(f[3:2] & e[3:2]); endproperty
	a_vec: assert property (p_vec) else $error("on time request wrong");
	property p_cyc; $stable(e) |-> cycle_end_source == (f[0] & e[0]); endproperty
	a_cyc: assert property (p_cyc) else $error("cycle end request wrong");
	property p_clr; s_clr |=> !f[0]; endproperty
	a_clr: assert property (p_clr) else $error("flag not cleared");
	property p_hold; f[0] && !(flag_write && flag_wdata[0]) |=> f[0]; endproperty
	a_hold: assert property (p_hold) else $error("flag lost");
	property p_cap; s_cap |=> !command_ready ##1 captured_count_a == $past(counter_value); endproperty
	a_cap: assert property (p_cap) else $error("capture wrong");
endmodule // wtu_oe_sva
bind wtu_output_events wtu_oe_sva chk (.*);

// [verification/wtu_evt_src.sv]
/* event network model driving event line a.
 assumes go is a one-cycle request on clk. */
module wtu_evt_src (
	input wire clk,
	input wire go,
	output logic event_in_a,
	output logic event_in_b
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] n_q = 3'h0;
	assign event_in_a = n_q != 3'h0;
	assign event_in_b = 1'b0;
	// held four cycles so the two-flop path sees it
	always @(posedge clk) begin
		if (go)
			n_q <= 3'h4;
		else if (n_q != 3'h0)
			n_q <= n_q - 3'h1;
	end
endmodule // wtu_evt_src

// [verification/tb.sv]
/* bench for wtu_output_events.
 assumes the event model and checker are compiled first. */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, reset_n = 0, por_n = 0, phase_active = 0, one_ramp_mode = 0, cycle_end_pulse = 0, go = 0;
	logic match_b_clear = 0, match_a_set = 0, match_b_set = 0, software_capture_a = 0, software_capture_b = 0;
	logic out_c_source_select = 0, out_d_source_select = 0, output_override = 0, fault_active = 0;
	logic key_write = 0, cpu_instr_done = 0, fault_ctrl_we = 0, blanking_used = 0, flag_write = 0;
	logic [1:0] counter_phase = 0, sleep_mode = 0, event_input_control = 0, input_mode_active = 0;
	logic [1:0] delay_trigger_select = 0, delay_clock_divider = 0, event_trigger_source = 0;
	logic [3:0] override_levels_a = 0, override_levels_b = 0, interrupt_enable_register = 4'hD, flag_wdata = 0;
	logic [7:0] fuse_output_defaults = 8'h5A, key_value = 8'hA5, fault_ctrl_wdata = 0, event_delay_count = 0;
	logic [11:0] counter_value = 0, v;
	logic [11:0] ex [2];
	logic [31:0] rs = 32'h00012AC1;
	logic ea, eb;
	wire command_ready, waveform_out_a, waveform_out_b, waveform_out_c, waveform_out_d, event_in_a, event_in_b;
	wire compare_b_clear_point, compare_a_set_point, compare_b_set_point, programmable_event;
	wire cycle_end_source, on_time_entry_vector;
	wire [1:0] counter_flow_event;
	wire [3:0] interrupt_flag_register;
	wire [7:0] output_fault_control;
	wire [11:0] captured_count_a, captured_count_b;
	int err_count = 0, check_count = 0, i, n, s;
	wtu_output_events uut (.*);
	wtu_evt_src evs (.clk(clk), .go(go), .event_in_a(event_in_a), .event_in_b(event_in_b));
	always #4 clk = ~clk;
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic tmo(input logic ok);
		if (ok !== 1'b1) begin
			chk("wait", ok, 12'h001);
			summarize();
		end
	endtask
	task automatic fw(input logic [3:0] d);
		@(posedge clk) flag_write <= 1'b1;
		flag_wdata <= d;
		@(posedge clk) flag_write <= 1'b0;
		cyc(1);
	endtask
	// key pulse, m instructions, then the protected write
	task automatic prot(input logic k, input int m, input logic [7:0] d);
		@(posedge clk) key_write <= k;
		@(posedge clk) key_write <= 1'b0;
		repeat (m) begin
			@(posedge clk) cpu_instr_done <= 1'b1;
			@(posedge clk) cpu_instr_done <= 1'b0;
		end
		@(posedge clk) fault_ctrl_we <= 1'b1;
		fault_ctrl_wdata <= d;
		@(posedge clk) fault_ctrl_we <= 1'b0;
		cyc(2);
	endtask
	initial begin
		cyc(2);
		@(posedge clk) reset_n <= 1'b1;
		por_n <= 1'b1;
		cyc(3);
		chk("fault", output_fault_control, 12'h05A);
		prot(1'b0, 1, 8'h11);
		chk("nokey", output_fault_control, 12'h05A);
		prot(1'b1, 5, 8'h11);
		chk("late", output_fault_control, 12'h05A);
		prot(1'b1, 2, 8'hF1);
		chk("key", output_fault_control, 12'h0F1);
		@(posedge clk) fault_active <= 1'b1;
		cyc(3);
		chk("flt a", waveform_out_a, 12'h001);
		chk("flt b", waveform_out_b, 12'h000);
		@(posedge clk) fault_active <= 1'b0;
		output_override <= 1'b1;
		phase_active <= 1'b1;
		$display("fault test done");
		for (i = 0; i < 8; i++) begin
			v = 12'(rnd());
			@(posedge clk) one_ramp_mode <= i[2];
			counter_phase <= 2'(i);
			{out_d_source_select, out_c_source_select, override_levels_b, override_levels_a} <= v[9:0];
			cyc(3);
			ea = v[(i[2] && i[1]) ? 0 : i % 4];
			eb = v[4 + ((i[2] && !i[1]) ? 0 : i % 4)];
			chk("ovr a", waveform_out_a, ea);
			chk("ovr b", waveform_out_b, eb);
			chk("out c", waveform_out_c, v[8] ? eb : ea);
			chk("out d", waveform_out_d, v[9] ? eb : ea);
		end
		@(posedge clk) output_override <= 1'b0;
		phase_active <= 1'b0;
		counter_phase <= 2'h0;
		fw(4'hF);
		$display("output test done");
		for (i = 0; i < 3; i++) begin
			v = 12'(rnd());
			@(posedge clk) sleep_mode <= 2'(i);
			counter_value <= v;
			{software_capture_b, software_capture_a} <= 2'(1 << i[0]);
			@(posedge clk) {software_capture_b, software_capture_a} <= 2'h0;
			if (i < 2)
				ex[i] = v;
			cyc(0);
			chk("rdy", command_ready, i / 2);
			cyc(1);
			chk("cap", i[0] ? captured_count_b : captured_count_a, ex[i[0]]);
			chk("flag", interrupt_flag_register[2 + i[0]], i < 2);
			chk("vec", on_time_entry_vector, i < 2);
			fw(4'hF);
			chk("clr", interrupt_flag_register, 12'h000);
		end
		@(posedge clk) sleep_mode <= 2'h0;
		cycle_end_pulse <= 1'b1;
		@(posedge clk) cycle_end_pulse <= 1'b0;
		fw(4'hE);
		chk("ovf", interrupt_flag_register[0], 12'h001);
		chk("ovf rq", cycle_end_source, 12'h001);
		fw(4'h1);
		chk("ovf clr", interrupt_flag_register[0], 12'h000);
		$display("capture test done");
		v = 12'(rnd());
		@(posedge clk) event_input_control <= 2'h1;
		input_mode_active <= 2'h1;
		counter_value <= v;
		go <= 1'b1;
		@(posedge clk) go <= 1'b0;
		for (i = 0; i < 20 && counter_flow_event[0] !== 1'b1; i++)
			cyc(1);
		tmo(counter_flow_event[0]);
		cyc(3);
		chk("ev cap", captured_count_a, v);
		for (s = 1; s < 4; s++) begin
			n = int'(rnd() % 8) + 1;
			v = 12'(rnd() % 4);
			@(posedge clk) delay_trigger_select <= 2'h2;
			delay_clock_divider <= v[1:0];
			event_trigger_source <= 2'(s);
			event_delay_count <= 8'(n);
			@(posedge clk) {match_b_clear, match_b_set, match_a_set} <= 3'(1 << (s - 1));
			@(posedge clk) {match_b_clear, match_b_set, match_a_set} <= 3'h0;
			for (i = 0; i < 300 && programmable_event !== 1'b1; i++)
				cyc(1);
			tmo(programmable_event);
			chk("delay", i, (n << v[1:0]) + 1);
		end
		$display("event test done");
		summarize();
	end
endmodule // tb
